/* rtl/serial_frame_transmitter.sv */
// Serial frame port: APB registers, frame transmitter, frame receiver and transfer clock
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
module serial_frame_transmitter
  import serial_frame_pkg::*;
#(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial lines
  output logic SERIAL_OUTPUT_PIN_O,
  output logic SERIAL_OUTPUT_PIN_OE,
  input wire logic SERIAL_INPUT_PIN,
  // Transfer clock pin
  input wire logic TRANSFER_CLOCK_PIN_I,
  output logic TRANSFER_CLOCK_PIN_O,
  output logic TRANSFER_CLOCK_PIN_OE
);

  typedef struct packed {
    logic [8:0] tx_buf;
    logic buf_full;
    logic [8:0] shift;
    logic [3:0] bit_cnt;
    tx_state_t tx_state;
    logic parity;
    logic txd;
    logic txd_oe;
    logic clk_out;
    logic clk_oe;
    logic [4:0] tx_presc;
    logic [BAUD_W-1:0] baud_cnt;
    logic [BAUD_W-1:0] baud_divisor;
    logic double_speed_bit;
    logic transmit_enable_bit;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic [2:0] character_size_field;
    logic [1:0] parity_mode_field;
    logic stop_bit_select;
    logic sync_mode_select;
    logic clock_polarity_select;
    logic clock_pin_direction;
    logic transmit_complete_flag;
    logic framing_error_flag;
    logic receive_complete_flag;
    logic [8:0] rx_data;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [4:0] rx_presc;
    rx_state_t rx_state;
    logic rxd_s1;
    logic rxd_s2;
    logic xck_s1;
    logic xck_s2;
    logic xck_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  localparam state_t STATE_RESET = '{
    txd: 1'b1, character_size_field: SIZE_RESET, rxd_s1: 1'b1, rxd_s2: 1'b1,
    tx_state: TX_IDLE, rx_state: RX_IDLE, default: '0};

  state_t s_q;
  state_t s_d;

  logic tick, clk_lvl, rise, fall, chg_edge, smp_edge, tx_step, rx_pulse;
  logic [3:0] nbits;
  logic [8:0] mask;
  logic [4:0] div;
  logic setup, access, wr_acc, rd_acc, mapped;
  logic load, done, txc_set, data_wr;

  assign tick = (s_q.baud_cnt == '0);
  // Asynchronous bit period in baud ticks; sync master toggles the pin every tick [R24]
  assign div = s_q.double_speed_bit ? DIV_DOUBLE : DIV_NORMAL;
  assign nbits = data_bits(s_q.character_size_field); // [R10] [R04]
  assign mask = ~(9'h1FF << nbits); // [R18]
  // Master reads its own clock, slave the synchronised pin [R23] [R01]
  assign clk_lvl = s_q.clock_pin_direction ? s_q.clk_out : s_q.xck_s2;
  assign rise = clk_lvl & ~s_q.xck_prev;
  assign fall = ~clk_lvl & s_q.xck_prev;
  assign chg_edge = s_q.sync_mode_select & (s_q.clock_polarity_select ? fall : rise); // [R03]
  assign smp_edge = s_q.sync_mode_select & (s_q.clock_polarity_select ? rise : fall); // [R02]
  assign tx_step = s_q.sync_mode_select ? chg_edge
                 : (tick && s_q.tx_presc >= div - 5'h01); // [R17]
  assign rx_pulse = s_q.sync_mode_select ? smp_edge
                  : (tick && s_q.rx_presc >= div - 5'h01);

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & s_q.pready;
  assign wr_acc = access & PWRITE;
  assign rd_acc = access & ~PWRITE;
  assign mapped = (PADDR == DATA_OFFSET) || (PADDR == STATUS_A_OFFSET)
               || (PADDR == CONTROL_B_OFFSET) || (PADDR == CONTROL_C_OFFSET)
               || (PADDR == BAUD_OFFSET) || (PADDR == PIN_DIR_OFFSET);
  assign data_wr = wr_acc && (PADDR == DATA_OFFSET);

  always_comb begin
    s_d = s_q;
    load = 1'b0;
    done = 1'b0;
    txc_set = 1'b0;

    // APB: one setup cycle, answer in the first access cycle
    s_d.pready = setup;
    if (setup) begin
      s_d.pslverr = ~mapped;
      s_d.prdata = 32'h0000_0000;
      case (PADDR)
        DATA_OFFSET: s_d.prdata[8:0] = s_q.rx_data;
        STATUS_A_OFFSET: begin
          s_d.prdata[RXC_POS] = s_q.receive_complete_flag;
          s_d.prdata[TXC_POS] = s_q.transmit_complete_flag;
          s_d.prdata[DRE_POS] = ~s_q.buf_full; // [R20]
          s_d.prdata[FE_POS] = s_q.framing_error_flag;
          s_d.prdata[DOUBLE_POS] = s_q.double_speed_bit;
        end
        CONTROL_B_OFFSET: begin
          s_d.prdata[RX_EN_POS] = s_q.receive_enable;
          s_d.prdata[TX_EN_POS] = s_q.transmit_enable_bit;
          s_d.prdata[SIZE2_POS] = s_q.character_size_field[2];
          s_d.prdata[RX_NINTH_POS] = s_q.rx_data[8];
          s_d.prdata[TX_NINTH_POS] = s_q.transmit_ninth_bit;
        end
        CONTROL_C_OFFSET: begin
          s_d.prdata[SYNC_POS] = s_q.sync_mode_select;
          s_d.prdata[PAR_LO_POS +: 2] = s_q.parity_mode_field;
          s_d.prdata[STOP_POS] = s_q.stop_bit_select;
          s_d.prdata[SIZE_LO_POS +: 2] = s_q.character_size_field[1:0];
          s_d.prdata[POL_POS] = s_q.clock_polarity_select;
        end
        BAUD_OFFSET: s_d.prdata[BAUD_W-1:0] = s_q.baud_divisor;
        PIN_DIR_OFFSET: s_d.prdata[CLK_DIR_POS] = s_q.clock_pin_direction;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Format fields are live: a change mid-frame reshapes the frame in flight [R09]
    if (wr_acc) begin
      case (PADDR)
        STATUS_A_OFFSET: s_d.double_speed_bit = PWDATA[DOUBLE_POS];
        CONTROL_B_OFFSET: begin
          s_d.receive_enable = PWDATA[RX_EN_POS];
          s_d.transmit_enable_bit = PWDATA[TX_EN_POS];
          s_d.character_size_field[2] = PWDATA[SIZE2_POS];
          s_d.transmit_ninth_bit = PWDATA[TX_NINTH_POS];
        end
        CONTROL_C_OFFSET: begin
          s_d.sync_mode_select = PWDATA[SYNC_POS];
          s_d.parity_mode_field = PWDATA[PAR_LO_POS +: 2];
          s_d.stop_bit_select = PWDATA[STOP_POS];
          s_d.character_size_field[1:0] = PWDATA[SIZE_LO_POS +: 2];
          s_d.clock_polarity_select = PWDATA[POL_POS];
        end
        BAUD_OFFSET: s_d.baud_divisor = PWDATA[BAUD_W-1:0];
        PIN_DIR_OFFSET: s_d.clock_pin_direction = PWDATA[CLK_DIR_POS];
        default: s_d.double_speed_bit = s_q.double_speed_bit;
      endcase
    end

    // Baud generator: reloads at zero or when the divisor is written
    if (wr_acc && PADDR == BAUD_OFFSET) begin
      s_d.baud_cnt = PWDATA[BAUD_W-1:0];
    end else if (tick) begin
      s_d.baud_cnt = s_q.baud_divisor;
    end else begin
      s_d.baud_cnt = s_q.baud_cnt - 1'b1;
    end
    if (tick) begin
      s_d.tx_presc = (s_q.tx_presc >= div - 5'h01) ? 5'h00 : s_q.tx_presc + 5'h01;
    end

    // Transfer clock: master toggles it on every baud tick [R24]
    s_d.xck_s1 = TRANSFER_CLOCK_PIN_I;
    s_d.xck_s2 = s_q.xck_s1;
    s_d.xck_prev = clk_lvl;
    if (s_q.sync_mode_select && s_q.clock_pin_direction) begin
      if (tick) begin
        s_d.clk_out = ~s_q.clk_out;
      end
    end else begin
      s_d.clk_out = 1'b0;
    end
    s_d.clk_oe = s_q.sync_mode_select & s_q.clock_pin_direction
               & (s_q.transmit_enable_bit | s_q.receive_enable); // [R01] [R14]

    // Transmitter: one step per bit period
    if (tx_step) begin
      case (s_q.tx_state)
        TX_IDLE: load = s_q.buf_full & s_q.transmit_enable_bit; // [R16]
        TX_START: begin
          s_d.txd = s_q.shift[0]; // [R05]
          s_d.shift = s_q.shift >> 1;
          s_d.bit_cnt = 4'h1;
          s_d.tx_state = TX_DATA;
        end
        TX_DATA: begin
          if (s_q.bit_cnt == nbits) begin
            if (s_q.parity_mode_field[1]) begin
              s_d.txd = s_q.parity; // [R06]
              s_d.tx_state = TX_PARITY;
            end else begin
              s_d.txd = 1'b1; // [R08]
              s_d.tx_state = TX_STOP1;
            end
          end else begin
            s_d.txd = s_q.shift[0]; // [R05]
            s_d.shift = s_q.shift >> 1;
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
        end
        TX_PARITY: begin
          s_d.txd = 1'b1; // [R08]
          s_d.tx_state = TX_STOP1;
        end
        TX_STOP1: begin
          if (s_q.stop_bit_select) begin
            s_d.tx_state = TX_STOP2;
          end else begin
            done = 1'b1;
          end
        end
        TX_STOP2: done = 1'b1;
        default: s_d.tx_state = TX_IDLE;
      endcase
      if (done) begin
        if (s_q.buf_full && s_q.transmit_enable_bit) begin
          load = 1'b1; // [R16]
        end else begin
          s_d.txd = 1'b1; // [R07]
          s_d.tx_state = TX_IDLE;
          txc_set = ~s_q.buf_full; // [R25]
        end
      end
      if (load) begin
        s_d.shift = s_q.tx_buf & mask; // [R18]
        s_d.parity = ^(s_q.tx_buf & mask) ^ s_q.parity_mode_field[0]; // [R12]
        s_d.txd = 1'b0; // [R08] [R05]
        s_d.tx_state = TX_START;
        s_d.buf_full = 1'b0;
      end
    end

    // Single-entry buffer; a write to a full buffer is dropped unless it empties now
    if (data_wr && (!s_q.buf_full || load)) begin
      s_d.tx_buf = {s_q.transmit_ninth_bit, PWDATA[7:0]}; // [R15]
      s_d.buf_full = 1'b1;
    end
    // Pin stays ours after a disable while a frame is in flight or a character waits in the buffer
    s_d.txd_oe = s_q.transmit_enable_bit | (s_q.tx_state != TX_IDLE) | s_q.buf_full; // [R13]

    // Set wins over a write-one clear in the same cycle
    s_d.transmit_complete_flag = (s_q.transmit_complete_flag
      & ~(wr_acc && PADDR == STATUS_A_OFFSET && PWDATA[TXC_POS])) | txc_set;

    // Receiver
    s_d.rxd_s1 = SERIAL_INPUT_PIN;
    s_d.rxd_s2 = s_q.rxd_s1;
    if (tick) begin
      s_d.rx_presc = (s_q.rx_presc >= div - 5'h01) ? 5'h00 : s_q.rx_presc + 5'h01;
    end
    if (!s_q.receive_enable) begin
      s_d.rx_state = RX_IDLE;
    end else begin
      case (s_q.rx_state)
        RX_IDLE: begin
          if (s_q.sync_mode_select) begin
            if (rx_pulse && !s_q.rxd_s2) begin
              s_d.rx_cnt = 4'h0;
              s_d.rx_state = RX_DATA; // [R02]
            end
          end else if (!s_q.rxd_s2) begin
            // Start sampling half a bit later, mid start bit
            s_d.rx_presc = div >> 1;
            s_d.rx_state = RX_START;
          end
        end
        RX_START: begin
          if (rx_pulse) begin
            s_d.rx_cnt = 4'h0;
            s_d.rx_state = s_q.rxd_s2 ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_pulse) begin
            s_d.rx_shift = {s_q.rxd_s2, s_q.rx_shift[8:1]};
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt + 4'h1 == nbits) begin
              s_d.rx_state = s_q.parity_mode_field[1] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: if (rx_pulse) s_d.rx_state = RX_STOP;
        RX_STOP: begin
          if (rx_pulse) begin
            s_d.framing_error_flag = ~s_q.rxd_s2; // [R11]
            s_d.rx_data = s_q.rx_shift >> (4'h9 - nbits);
            s_d.rx_state = RX_IDLE; // [R11]
          end
        end
        default: s_d.rx_state = RX_IDLE;
      endcase
    end
    s_d.receive_complete_flag = (s_q.receive_complete_flag & ~(rd_acc && PADDR == DATA_OFFSET))
      | (s_q.receive_enable && s_q.rx_state == RX_STOP && rx_pulse);
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign SERIAL_OUTPUT_PIN_O = s_q.txd;
  assign SERIAL_OUTPUT_PIN_OE = s_q.txd_oe;
  assign TRANSFER_CLOCK_PIN_O = s_q.clk_out;
  assign TRANSFER_CLOCK_PIN_OE = s_q.clk_oe;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  start_bit_low_a: assert property ( // [R08]
    s_q.tx_state == TX_START |-> s_q.txd == 1'b0)
    else $error("start bit not low");

  stop_bits_high_a: assert property ( // [R08]
    (s_q.tx_state == TX_STOP1 || s_q.tx_state == TX_STOP2) |-> s_q.txd == 1'b1)
    else $error("stop bit not high");

  idle_line_high_a: assert property ( // [R07]
    s_q.tx_state == TX_IDLE |-> s_q.txd == 1'b1)
    else $error("idle line not high");

  parity_value_a: assert property ( // [R12]
    s_q.tx_state == TX_PARITY |-> s_q.txd == (^(s_q.tx_buf & mask) ^ s_q.parity_mode_field[0])
      || $past(data_wr, 1) || s_q.buf_full)
    else $error("parity bit wrong");

  buffer_load_a: assert property ( // [R16]
    (tx_step && s_q.tx_state == TX_IDLE && s_q.buf_full && s_q.transmit_enable_bit)
      |=> s_q.tx_state == TX_START ##1 s_q.tx_state == TX_START [*1])
    else $error("buffer not moved to shifter");

  data_write_a: assert property ( // [R15]
    (data_wr && !s_q.buf_full) |=> s_q.buf_full && s_q.tx_buf[7:0] == $past(PWDATA[7:0]))
    else $error("data write did not fill buffer");

  unused_bits_a: assert property ( // [R18]
    $rose(s_q.tx_state == TX_START) |-> (s_q.shift & ~mask) == 9'h000)
    else $error("unused data bits sent");

  complete_flag_a: assert property ( // [R25]
    $rose(s_q.transmit_complete_flag) |-> s_q.tx_state == TX_IDLE && !s_q.buf_full
      && ($past(s_q.tx_state) == TX_STOP1 || $past(s_q.tx_state) == TX_STOP2))
    else $error("complete flag at wrong time");

  clock_pin_dir_a: assert property ( // [R01] [R14]
    TRANSFER_CLOCK_PIN_OE == $past(s_q.sync_mode_select && s_q.clock_pin_direction
      && (s_q.transmit_enable_bit || s_q.receive_enable)))
    else $error("clock pin direction wrong");

  sync_change_edge_a: assert property ( // [R03]
    ($past(s_q.sync_mode_select) && s_q.sync_mode_select && $changed(s_q.txd))
      |-> $past(chg_edge))
    else $error("data changed off the change edge");

  framing_error_a: assert property ( // [R11]
    (s_q.receive_enable && s_q.rx_state == RX_STOP && rx_pulse && !s_q.rxd_s2)
      |=> s_q.framing_error_flag && s_q.rx_state == RX_IDLE)
    else $error("framing error missed");

  parity_frame_c: cover property (s_q.tx_state == TX_PARITY ##[1:300] s_q.tx_state == TX_STOP1);
  back_to_back_c: cover property (s_q.tx_state == TX_STOP1 ##1 s_q.tx_state == TX_START);
  sync_master_c: cover property (TRANSFER_CLOCK_PIN_OE && s_q.tx_state == TX_DATA);
  rx_complete_c: cover property ($rose(s_q.receive_complete_flag));

endmodule // serial_frame_transmitter

/* rtl/serial_frame_pkg.sv */
// Register map, field positions, reset values and state types of the serial frame transmitter
// How it works
// (R01) Sync mode: clock pin slave input, master output
// (R02) Receive samples on edge opposite transmit change
// (R03) Polarity zero: change rising, sample falling
// (R04) All thirty start/data/parity/stop combinations supported
// (R05) Start bit, then data least significant first
// (R06) Parity bit after data, before first stop
// (R07) After frame: next start or idle high
// (R08) Start bit low, every stop bit high
// (R09) One shared format; changes may corrupt traffic
// (R10) Size field, parity field, stop select bit
// (R11) Receiver ignores second stop; framing error first
// (R12) Parity: xor of data, inverted when odd
// (R13) Transmit enable takes over the output pin
// (R14) Sync transmitter takes over the clock pin
// (R15) Data register write loads one-entry buffer
// (R16) Buffer moves to shifter when idle or frame-end
// (R17) Frame sent at baud rate or external clock
// (R18) Unused high data bits ignored for short characters
// (R19) Software writes ninth bit before low byte
// (R20) Empty flag shows buffer can take a character
// (R21) Software changes format only when transfers idle
// (R22) Software clears complete flag before data write
// (R23) Clock pin direction picks master or slave
// (R24) Bit clock: baud tick over 16, 8 or 2
// (R25) Complete flag set when frame out, buffer empty
package serial_frame_pkg;

  localparam logic [7:0] DATA_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_A_OFFSET = 8'h04;
  localparam logic [7:0] CONTROL_B_OFFSET = 8'h08;
  localparam logic [7:0] CONTROL_C_OFFSET = 8'h0C;
  localparam logic [7:0] BAUD_OFFSET = 8'h10;
  localparam logic [7:0] PIN_DIR_OFFSET = 8'h14;

  // Status A fields
  localparam int RXC_POS = 7;
  localparam int TXC_POS = 6;
  localparam int DRE_POS = 5;
  localparam int FE_POS = 4;
  localparam int DOUBLE_POS = 1;
  // Control B fields
  localparam int RX_EN_POS = 4;
  localparam int TX_EN_POS = 3;
  localparam int SIZE2_POS = 2;
  localparam int RX_NINTH_POS = 1;
  localparam int TX_NINTH_POS = 0;
  // Control C fields, then the pin direction field
  localparam int SYNC_POS = 6;
  localparam int PAR_LO_POS = 4;
  localparam int STOP_POS = 3;
  localparam int SIZE_LO_POS = 1;
  localparam int POL_POS = 0;
  localparam int CLK_DIR_POS = 0;

  localparam logic [2:0] SIZE_RESET = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [4:0] DIV_NORMAL = 5'h10;
  localparam logic [4:0] DIV_DOUBLE = 5'h08;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
    TX_PARITY = 3'h2, TX_STOP1 = 3'h6, TX_STOP2 = 3'h7
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PARITY = 3'h2, RX_STOP = 3'h6
  } rx_state_t;

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      SIZE_NINE: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

endpackage

/* verif/serial_partner.sv */
// Remote serial receiver that rebuilds frames from the transmit line
`timescale 1ns/10ps
module serial_partner (
  // Line side
  input wire logic clk,
  input wire logic line,
  input wire logic xck,
  // Frame format
  input wire logic sync,
  input wire logic pol,
  input wire logic par_en,
  input wire logic two_stop,
  input wire logic [3:0] nbits,
  input wire logic [7:0] bit_cycles,
  // Decoded frame
  output logic got,
  output logic [8:0] word,
  output logic par,
  output logic [1:0] stops
);
  logic xck_q;
  logic [8:0] w;
  logic [1:0] s;
  logic p;

  // Sampled on the falling MCLK edge, clear of the edge that moves the pins
  always @(negedge clk) xck_q <= xck;

  // Next sample point: the edge opposite the change edge, or one bit time
  task automatic step();
    if (sync) begin
      do @(negedge clk); while (!(xck !== xck_q && xck === pol));
    end else begin
      repeat (bit_cycles) @(negedge clk);
    end
  endtask

  initial begin
    got = 1'b0;
    forever begin
      w = 9'h000;
      p = 1'b0;
      s = 2'h3;
      // Mode is looked at on every idle sample, so a switch while waiting is followed
      do begin
        if (sync) begin
          step();
        end else begin
          @(negedge clk);
        end
      end while (line !== 1'b0);
      // Move to mid-bit so small skews cannot flip a sample
      if (!sync) begin
        repeat (bit_cycles / 2) @(negedge clk);
      end
      for (int i = 0; i < nbits; i++) begin
        step();
        w[i] = line;
      end
      if (par_en) begin
        step();
        p = line;
      end
      step();
      s[0] = line;
      if (two_stop) begin
        step();
        s[1] = line;
      end
      got <= 1'b1;
      word <= w;
      par <= p;
      stops <= s;
      @(negedge clk);
      got <= 1'b0;
    end
  end
endmodule // serial_partner

/* verif/serial_frame_transmitter_tb.sv */
// Self-checking bench: APB driver, frame scoreboard and remote receiver
`timescale 1ns/10ps
module serial_frame_transmitter_tb;
  import serial_frame_pkg::*;
  `define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic tx_o, tx_oe, ck_o, ck_oe, err, got, par, sync_c, pol_c, par_en, par_odd, two_stop;
  logic [7:0] paddr, bitc, cb;
  logic [31:0] pwdata, prdata, rd, seed, r;
  logic [8:0] word;
  logic [1:0] stops, pc;
  logic [3:0] nbits;
  logic [2:0] sz;
  logic [9:0] e;
  logic [9:0] expq[$];
  logic dbl, sclk, srun;
  logic [2:0] sdiv;
  int miscompares, checks, cyc;
  // Pull-up on the data line; the far end holds the clock pin low unless it clocks a slave
  wire logic line = tx_oe ? tx_o : 1'b1;
  wire logic xck = ck_oe ? ck_o : sclk;

  serial_frame_transmitter #(.BAUD_W(12)) uut (
    .MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_OUTPUT_PIN_O(tx_o), .SERIAL_OUTPUT_PIN_OE(tx_oe), .SERIAL_INPUT_PIN(line),
    .TRANSFER_CLOCK_PIN_I(xck), .TRANSFER_CLOCK_PIN_O(ck_o), .TRANSFER_CLOCK_PIN_OE(ck_oe)
  );

  serial_partner far_end (
    .clk(mclk), .line(line), .xck(xck), .sync(sync_c), .pol(pol_c), .par_en(par_en),
    .two_stop(two_stop), .nbits(nbits), .bit_cycles(bitc), .got(got), .word(word),
    .par(par), .stops(stops)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // The answer is looked at where it stands settled, before the edge that completes it
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_flag(input int pos, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, STATUS_A_OFFSET, 32'h0);
      n++;
    end while (rd[pos] !== v && n < 400);
    `CHK("flag wait", rd[pos], v)
  endtask

  task automatic send(input logic [8:0] d);
    logic [8:0] m;
    m = d & ((9'h001 << nbits) - 9'h001);
    expq.push_back({par_en & (^m ^ par_odd), m});
    wait_flag(DRE_POS, 1'b1);
    apb(1'b1, CONTROL_B_OFFSET, 32'(cb) | 32'(d[8]));
    apb(1'b1, DATA_OFFSET, 32'(d[7:0]));
  endtask

  always @(posedge mclk) begin
    if (got === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK("frame count", 1'b0, 1'b1)
      end else begin
        e = expq.pop_front();
        `CHK("data", word, e[8:0])
        `CHK("parity", par, e[9])
        `CHK("stop bits", stops, 2'h3)
      end
    end
  end

  // Far-end clock for slave transfers, toggled every six MCLK cycles while enabled
  always @(posedge mclk) begin
    if (srun) begin
      sdiv <= (sdiv == 3'h5) ? 3'h0 : sdiv + 3'h1;
      if (sdiv == 3'h5) begin
        sclk <= ~sclk;
      end
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    {reset_n, psel, penable, pwrite, sync_c, pol_c, par_en, par_odd, two_stop} = 9'h000;
    {sclk, srun} = 2'h0;
    sdiv = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h0000A950;
    nbits = 4'h8;
    bitc = 8'h20;
    cb = 8'h18;
    miscompares = 0;
    checks = 0;
    cyc = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    `CHK("idle line", tx_o, 1'b1)
    `CHK("pin free", tx_oe, 1'b0)
    @(posedge mclk);
    apb(1'b0, CONTROL_C_OFFSET, 32'h0);
    `CHK("format reset", rd, 32'h00000006)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped error", err, 1'b1)
    `CHK("unmapped data", rd, 32'h0)
    apb(1'b1, BAUD_OFFSET, 32'h1);
    // All thirty formats, each with two characters sent back to back
    for (int f = 0; f < 30; f++) begin
      sz = (f % 5 == 4) ? SIZE_NINE : 3'(f % 5);
      nbits = data_bits(sz);
      pc = (f / 5 % 3 == 0) ? 2'h0 : {1'b1, f / 5 % 3 == 2};
      par_en = pc[1];
      par_odd = pc[0];
      two_stop = f >= 15;
      dbl = f / 3 % 2;
      bitc = dbl ? 8'h10 : 8'h20;
      cb = 8'h18 | (8'(sz[2]) << 2);
      apb(1'b1, STATUS_A_OFFSET, 32'(dbl) << DOUBLE_POS);
      apb(1'b1, CONTROL_C_OFFSET, 32'({pc, two_stop, sz[1:0], 1'b0}));
      apb(1'b1, CONTROL_B_OFFSET, 32'(cb));
      @(negedge mclk);
      `CHK("pin owned", tx_oe, 1'b1)
      @(posedge mclk);
      r = xs();
      send(r[8:0]);
      send(r[24:16]);
      apb(1'b0, STATUS_A_OFFSET, 32'h0);
      `CHK("buffer full", rd[DRE_POS], 1'b0)
      `CHK("not complete", rd[TXC_POS], 1'b0)
      wait_flag(TXC_POS, 1'b1);
      `CHK("complete", rd[TXC_POS], 1'b1)
      `CHK("frames out", 32'(expq.size()), 32'h0)
      apb(1'b1, STATUS_A_OFFSET, (32'h1 << TXC_POS) | (32'(dbl) << DOUBLE_POS));
      apb(1'b0, STATUS_A_OFFSET, 32'h0);
      `CHK("complete cleared", rd[TXC_POS], 1'b0)
    end
    // Synchronous master, both clock polarities, 8 bits even parity
    apb(1'b1, BAUD_OFFSET, 32'h3);
    apb(1'b1, STATUS_A_OFFSET, 32'h0);
    apb(1'b1, PIN_DIR_OFFSET, 32'h1);
    {nbits, par_en, par_odd, two_stop, cb} = {4'h8, 3'h4, 8'h18};
    for (int p = 0; p < 2; p++) begin
      pol_c = p[0];
      sync_c = 1'b1;
      apb(1'b1, CONTROL_C_OFFSET, 32'h00000066 | 32'(p));
      apb(1'b1, CONTROL_B_OFFSET, 32'(cb));
      @(negedge mclk);
      `CHK("clock pin driven", ck_oe, 1'b1)
      @(posedge mclk);
      r = xs();
      send(r[8:0]);
      wait_flag(TXC_POS, 1'b1);
      `CHK("sync frames out", 32'(expq.size()), 32'h0)
      apb(1'b1, STATUS_A_OFFSET, 32'h1 << TXC_POS);
    end
    // Synchronous slave: the far end clocks the pin at a twelfth of MCLK, inside the limit
    apb(1'b1, PIN_DIR_OFFSET, 32'h0);
    @(negedge mclk);
    `CHK("clock pin released", ck_oe, 1'b0)
    @(posedge mclk);
    srun <= 1'b1;
    r = xs();
    send(r[8:0]);
    wait_flag(TXC_POS, 1'b1);
    `CHK("slave frames out", 32'(expq.size()), 32'h0)
    srun <= 1'b0;
    results();
  end
endmodule // serial_frame_transmitter_tb
